//--- core/adcs_pkg.sv
// Shared constants and types for the conversion start and readback block.
package adcs_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    // System clock period and the conversion clock period, both in ns.
    localparam int CLK_PERIOD_NS  = 8;
    localparam int CONVERSION_CLOCK_PERIOD_NS = 400;
    // The conversion clock is made by toggling every half period.
    localparam int CONVERSION_CLOCK_HALF_CYC  = CONVERSION_CLOCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    // A conversion lasts this many divided-clock periods, busy-low period included.
    localparam int CONV_DIVIDED_CONVERSION_CLOCK_PERIODS = 14;
    // Falling edges of the start clock between a request and the start.
    localparam int START_EDGES       = 2;

    // ****************************************************************
    // Widths and result layout
    // ****************************************************************
    localparam int RESULT_W   = 12;
    localparam int WORD_W     = 16;
    localparam int BYTE_BITS  = 8;
    // Result is left-justified in the 16-bit output word.
    localparam int RESULT_LSB = WORD_W - RESULT_W;

    // ****************************************************************
    // Readback modes
    // ****************************************************************
    typedef enum logic [1:0] {
        RB_MANUAL    = 2'b00,
        RB_AUTO_MSB  = 2'b01,
        RB_AUTO_LSB  = 2'b10,
        RB_AUTO_HIGH = 2'b11
    } adcs_rb_mode_t;

    // Conversion sequencer states.
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_WAIT = 2'b01,
        CS_CONV = 2'b10
    } adcs_conv_state_t;

    // Requests decoded by the serial front end, one-cycle pulses.
    typedef struct packed {
        logic start;     // Eighth active edge of a start byte or start-bit write.
        logic read;      // Eighth active edge of a result read instruction.
        logic addr_high; // Read addresses the high-byte register.
        logic len16;     // Read is 16 bits long, else 8.
    } adcs_ser_req_t;

endpackage

//--- core/adcs_start_readback.sv
// Conversion start sequencing, start queue, busy timing and result readback.
//
// Behaviour
// - Start on start byte or start-bit write.
// - Serial start on second divided-clock fall.
// - Busy rises one divided period after start.
// - Serial start during conversion is queued.
// - Queue holds one; newer start overwrites.
// - Queued start follows immediately, busy low.
// - Pin start on second conversion-clock fall.
// - Pin start aborts and restarts conversion.
// - Pin start honoured whatever chip select.
// - Two-bit readback mode, manual default.
// - Only serial starts arm automatic readback.
// - High-byte mode still converts fully.
// - First bit active edge, rest inactive.
// - Manual reads: address, length set order.
// - Read returns last result before data.
// - Mode 1 acts as 16-bit high read.
// - Mode 2 acts as 16-bit low read.
// - Mode 3 acts as 8-bit high read.
`timescale 1ns/1ps

module adcs_start_readback
    import adcs_pkg::*;
(
    input  wire logic                clk_sys_i,
    input  wire logic                rst_n_i,
    input  wire adcs_ser_req_t       ser_req_i,
    input  wire logic                convert_pin_i,
    input  wire logic                sclk_pin_i,
    input  wire logic                cs_n_pin_i,
    input  wire logic                sclk_active_rise_i,
    input  wire logic                clock_divider_bit_high_i,
    input  wire logic                clock_divider_bit_low_i,
    input  wire logic                readback_select_high_i,
    input  wire logic                readback_select_low_i,
    input  wire logic [RESULT_W-1:0] adc_data_i,
    output logic                     busy_o,
    output logic                     conversion_clock_o,
    output logic                     divided_conversion_clock_o,
    output logic                     sample_done_o,
    output logic [RESULT_W-1:0]      result_o,
    output logic                     dout_o,
    output logic                     dout_oe_n_o
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Three stages per pin; a level is accepted once stages two and three agree.
    // The filtered level is what the rest of the block looks at.
    localparam int NPIN = 3;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [NPIN-1:0] pin_s3;
    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] pin_lvl_d;

    assign pin_raw = {cs_n_pin_i, sclk_pin_i, convert_pin_i};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            // Chip select idles high, the others idle low.
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pin_s1[gi]    <= (gi == 2) ? 1'b1 : 1'b0;
                    pin_s2[gi]    <= (gi == 2) ? 1'b1 : 1'b0;
                    pin_s3[gi]    <= (gi == 2) ? 1'b1 : 1'b0;
                    pin_lvl[gi]   <= (gi == 2) ? 1'b1 : 1'b0;
                    pin_lvl_d[gi] <= (gi == 2) ? 1'b1 : 1'b0;
                end else begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi]) begin
                        pin_lvl[gi] <= pin_s3[gi];
                    end
                    pin_lvl_d[gi] <= pin_lvl[gi];
                end
            end
        end
    endgenerate

    logic convert_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_n_lvl;
    logic sclk_act;
    logic sclk_inact;

    // Chip select plays no part in the pin start path.
    assign convert_rise = pin_lvl[0] & ~pin_lvl_d[0];
    assign sclk_rise    = pin_lvl[1] & ~pin_lvl_d[1];
    assign sclk_fall    = ~pin_lvl[1] & pin_lvl_d[1];
    assign cs_n_lvl     = pin_lvl[2];
    assign sclk_act     = sclk_active_rise_i ? sclk_rise : sclk_fall;
    assign sclk_inact   = sclk_active_rise_i ? sclk_fall : sclk_rise;

    // ****************************************************************
    // Conversion clock and divided clock
    // ****************************************************************
    localparam int HALF_W = $clog2(CONVERSION_CLOCK_HALF_CYC + 1);
    logic [HALF_W-1:0] half_cnt;
    logic              conversion_clock;
    logic              conversion_clock_fall;
    logic [2:0]        div_cnt;
    logic [2:0]        div_mask;
    logic              divided_conversion_clock_fall;
    logic              conv_start;

    // A falling conversion-clock edge is the end of the high half period.
    assign conversion_clock_fall = conversion_clock & (half_cnt == HALF_W'(CONVERSION_CLOCK_HALF_CYC - 1));

    // Divider ratio 1, 2, 4 or 8 from the two divider bits.
    always_comb begin
        unique case ({clock_divider_bit_high_i, clock_divider_bit_low_i})
            2'b00: div_mask = 3'h0;
            2'b01: div_mask = 3'h1;
            2'b10: div_mask = 3'h3;
            2'b11: div_mask = 3'h7;
        endcase
    end

    assign divided_conversion_clock_fall = conversion_clock_fall & (div_cnt == div_mask);

    // Free-running conversion clock.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            half_cnt <= '0;
            conversion_clock     <= 1'b0;
        end else if (half_cnt == HALF_W'(CONVERSION_CLOCK_HALF_CYC - 1)) begin
            half_cnt <= '0;
            conversion_clock     <= ~conversion_clock;
        end else begin
            half_cnt <= half_cnt + HALF_W'(1);
        end
    end

    // The divider is realigned at each start so busy timing counts from it.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= 3'h0;
        end else if (conv_start || divided_conversion_clock_fall) begin
            div_cnt <= 3'h0;
        end else if (conversion_clock_fall) begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    assign conversion_clock_o         = conversion_clock;
    assign divided_conversion_clock_o = (div_cnt <= (div_mask >> 1)) ? conversion_clock : 1'b0;

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    adcs_conv_state_t state;
    logic             wait_pin;
    logic [1:0]       edge_cnt;
    logic             queued;
    logic [3:0]       period_cnt;
    logic             wait_edge;
    logic             conv_end;

    // Serial starts wait on divided-clock falls, pin starts on conversion-clock falls.
    assign wait_edge  = wait_pin ? conversion_clock_fall : divided_conversion_clock_fall;
    assign conv_end   = (state == CS_CONV) & divided_conversion_clock_fall
                      & (period_cnt == 4'(CONV_DIVIDED_CONVERSION_CLOCK_PERIODS - 1));
    assign conv_start = ((state == CS_WAIT) & wait_edge
                         & (edge_cnt == 2'(START_EDGES - 1)) & ~convert_rise)
                      | (conv_end & (queued | ser_req_i.start) & ~convert_rise);

    // The pin edge wins over everything, aborting a running conversion.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state    <= CS_IDLE;
            wait_pin <= 1'b0;
            edge_cnt <= 2'h0;
        end else if (convert_rise) begin
            state    <= CS_WAIT;
            wait_pin <= 1'b1;
            edge_cnt <= 2'h0;
        end else if (conv_start) begin
            state <= CS_CONV;
        end else if (conv_end) begin
            state <= CS_IDLE;
        end else if (ser_req_i.start && (state == CS_IDLE)) begin
            state    <= CS_WAIT;
            wait_pin <= 1'b0;
            edge_cnt <= 2'h0;
        end else if ((state == CS_WAIT) && wait_edge) begin
            edge_cnt <= edge_cnt + 2'h1;
        end
    end

    // One-deep queue: a second request just leaves the flag set.
    // A request in the completion cycle starts the next conversion at once.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            queued <= 1'b0;
        end else if (convert_rise) begin
            queued <= 1'b0;
        end else if (ser_req_i.start && (state == CS_CONV) && !conv_end) begin
            queued <= 1'b1;
        end else if (conv_end) begin
            queued <= 1'b0;
        end
    end

    // Period zero keeps busy low so its falling edge marks back-to-back starts.
    // High-byte readback never shortens this count.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            period_cnt <= 4'h0;
        end else if (conv_start) begin
            period_cnt <= 4'h0;
        end else if ((state == CS_CONV) && divided_conversion_clock_fall) begin
            period_cnt <= period_cnt + 4'h1;
        end
    end

    // Busy rises one divided period after start and drops at the end.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
        end else if (conv_start || conv_end || convert_rise) begin
            busy_o <= 1'b0;
        end else if ((state == CS_CONV) && divided_conversion_clock_fall) begin
            busy_o <= 1'b1;
        end
    end

    // Result register holds the last completed conversion.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_o      <= '0;
            sample_done_o <= 1'b0;
        end else begin
            sample_done_o <= conv_end;
            if (conv_end) begin
                result_o <= adc_data_i;
            end
        end
    end

    // ****************************************************************
    // Readback
    // ****************************************************************
    adcs_rb_mode_t rb_mode;
    logic          auto_req;
    logic          frame_req;
    logic          frame_hi;
    logic          frame_16;
    logic          rd_armed;
    logic          rd_loaded;
    logic          rd_hi_first;
    logic          rd_16;
    logic [4:0]    rd_idx;
    logic [WORD_W-1:0] snap;
    logic [WORD_W-1:0] live_word;

    assign rb_mode = adcs_rb_mode_t'({readback_select_high_i, readback_select_low_i});

    // Only a serial start arms automatic readback; pin starts never do.
    assign auto_req  = ser_req_i.start & (rb_mode != RB_MANUAL) & ~cs_n_lvl;
    assign frame_req = ser_req_i.read | auto_req;
    assign live_word = {result_o, RESULT_LSB'(0)};

    // Byte order and length of each readback source.
    always_comb begin
        frame_hi = ser_req_i.addr_high;
        frame_16 = ser_req_i.len16;
        if (auto_req) begin
            unique case (rb_mode)
                RB_AUTO_MSB: begin
                    frame_hi = 1'b1;
                    frame_16 = 1'b1;
                end
                RB_AUTO_LSB: begin
                    frame_hi = 1'b0;
                    frame_16 = 1'b1;
                end
                RB_AUTO_HIGH: begin
                    frame_hi = 1'b1;
                    frame_16 = 1'b0;
                end
                RB_MANUAL: begin
                    frame_hi = ser_req_i.addr_high;
                    frame_16 = ser_req_i.len16;
                end
            endcase
        end
    end

    // Bit number k of a frame: bytes in chosen order, each byte MSB first.
    function automatic logic frame_bit(input logic [WORD_W-1:0] w,
                                       input logic              hi_first,
                                       input logic [4:0]        k);
        logic [3:0] pos;
        pos = 4'(BYTE_BITS - 1) - {1'b0, k[2:0]};
        if (k[3] ^ hi_first) begin
            frame_bit = w[{1'b1, pos[2:0]}];
        end else begin
            frame_bit = w[{1'b0, pos[2:0]}];
        end
    endfunction

    // Frame setup and bit position tracking; chip select high ends the frame.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_armed    <= 1'b0;
            rd_loaded   <= 1'b0;
            rd_hi_first <= 1'b1;
            rd_16       <= 1'b0;
            rd_idx      <= 5'h00;
        end else if (cs_n_lvl) begin
            rd_armed  <= 1'b0;
            rd_loaded <= 1'b0;
        end else if (frame_req) begin
            rd_armed    <= 1'b1;
            rd_loaded   <= 1'b0;
            rd_hi_first <= frame_hi;
            rd_16       <= frame_16;
            rd_idx      <= 5'h00;
        end else if (rd_armed && !rd_loaded && sclk_act) begin
            rd_loaded <= 1'b1;
            rd_idx    <= 5'h01;
        end else if (rd_loaded && sclk_inact) begin
            if (rd_idx == (rd_16 ? 5'(WORD_W) : 5'(BYTE_BITS))) begin
                rd_armed  <= 1'b0;
                rd_loaded <= 1'b0;
            end else begin
                rd_idx <= rd_idx + 5'h01;
            end
        end
    end

    // Snapshot at the first active edge fixes which result the frame carries.
    // A completion between that edge and the next inactive edge is not seen.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            snap <= '0;
        end else if (rd_armed && !rd_loaded && sclk_act && !cs_n_lvl && !frame_req) begin
            snap <= live_word;
        end
    end

    // First bit goes out on the active edge, the rest on inactive edges.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_o      <= 1'b0;
            dout_oe_n_o <= 1'b1;
        end else if (cs_n_lvl || frame_req) begin
            dout_oe_n_o <= 1'b1;
        end else if (rd_armed && !rd_loaded && sclk_act) begin
            dout_o      <= frame_bit(live_word, rd_hi_first, 5'h00);
            dout_oe_n_o <= 1'b0;
        end else if (rd_loaded && sclk_inact) begin
            if (rd_idx == (rd_16 ? 5'(WORD_W) : 5'(BYTE_BITS))) begin
                dout_oe_n_o <= 1'b1;
            end else begin
                dout_o <= frame_bit(snap, rd_hi_first, rd_idx);
            end
        end
    end

endmodule

//--- verification/adcs_start_readback_props.sv
// Concurrent checks on the ports of the conversion start and readback block.
`timescale 1ns/1ps

module adcs_start_readback_props
    import adcs_pkg::*;
(
    input wire logic                clk_sys_i,
    input wire logic                rst_n_i,
    input wire logic                cs_n_pin_i,
    input wire logic                sclk_pin_i,
    input wire logic                sclk_active_rise_i,
    input wire logic                busy_o,
    input wire logic                conversion_clock_o,
    input wire logic                sample_done_o,
    input wire logic [RESULT_W-1:0] result_o,
    input wire logic                dout_o,
    input wire logic                dout_oe_n_o
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    int unsigned low_cnt;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // Busy-low run length; saturates so it never wraps in a long idle.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_cnt <= 0;
        end else if (busy_o) begin
            low_cnt <= 0;
        end else if (low_cnt < 1000) begin
            low_cnt <= low_cnt + 1;
        end
    end

    sequence s_cs_idle;
        cs_n_pin_i [*8];
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    busy_gap_a: assert property ($rose(busy_o) |-> low_cnt >= 45)
        else $error("busy rose before one divided period");
    done_idle_a: assert property (sample_done_o |-> !busy_o)
        else $error("busy high at completion");
    result_done_a: assert property ($changed(result_o) |-> sample_done_o)
        else $error("result changed without completion");
    dout_hold_a: assert property ((!dout_oe_n_o && $past(!dout_oe_n_o) && $changed(dout_o))
        |-> sclk_pin_i != sclk_active_rise_i)
        else $error("data bit changed outside an inactive edge");
    oe_start_a: assert property ($fell(dout_oe_n_o) |-> sclk_pin_i == sclk_active_rise_i)
        else $error("output enabled outside an active edge");
    cs_idle_a: assert property (s_cs_idle |-> dout_oe_n_o)
        else $error("output driven while deselected");
    conversion_clock_half_a: assert property ($changed(conversion_clock_o)
        |=> $stable(conversion_clock_o) [*8])
        else $error("conversion clock half period too short");
    done_pulse_a: assert property ($rose(sample_done_o) |=> !sample_done_o [*8])
        else $error("completion pulse too long or too close");
endmodule

bind adcs_start_readback adcs_start_readback_props u_adcs_start_readback_props (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_pin_i(cs_n_pin_i),
    .sclk_pin_i(sclk_pin_i), .sclk_active_rise_i(sclk_active_rise_i),
    .busy_o(busy_o), .conversion_clock_o(conversion_clock_o),
    .sample_done_o(sample_done_o), .result_o(result_o), .dout_o(dout_o),
    .dout_oe_n_o(dout_oe_n_o));

//--- verification/adcs_host_model.sv
// Host controller model: serial clock, chip select and start pin.
`timescale 1ns/1ps

module adcs_host_model (
    input  wire logic clk_sys_i,
    input  wire logic sclk_active_rise_i,
    input  wire logic dout_o,
    input  wire logic dout_oe_n_o,
    output logic      sclk_pin,
    output logic      cs_n_pin,
    output logic      convert_pin
);
    // Half serial period in system cycles; well above the pin sync lag.
    localparam int HALF = 16;

    initial begin
        sclk_pin    = 1'b0;
        cs_n_pin    = 1'b1;
        convert_pin = 1'b0;
    end

    // Select or deselect; the clock parks at its inactive level between frames.
    task automatic select(input logic on);
        @(posedge clk_sys_i);
        sclk_pin <= !sclk_active_rise_i;
        cs_n_pin <= !on;
        repeat (HALF) @(posedge clk_sys_i);
    endtask

    // Pin pulse: low and high each two conversion-clock periods or more.
    task automatic pin_pulse();
        @(posedge clk_sys_i);
        convert_pin <= 1'b1;
        repeat (110) @(posedge clk_sys_i);
        convert_pin <= 1'b0;
        repeat (110) @(posedge clk_sys_i);
    endtask

    // Clock out n bits, sampling each just before its inactive edge.
    task automatic frame(input int n, output logic [15:0] got, output int lows,
                         output logic end_hi);
        got  = '0;
        lows = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_i);
            sclk_pin <= sclk_active_rise_i;
            repeat (HALF) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            got = {got[14:0], dout_oe_n_o ? !dout_o : dout_o}; // Released line reads inverted.
            if (dout_oe_n_o === 1'b0) lows++;
            @(posedge clk_sys_i);
            sclk_pin <= !sclk_active_rise_i;
            repeat (HALF) @(posedge clk_sys_i);
        end
        @(negedge clk_sys_i);
        end_hi = dout_oe_n_o;
    endtask
endmodule

//--- verification/tb.sv
// Self-checking testbench for the conversion start and readback block.
`timescale 1ns/1ps

module tb;
    import adcs_pkg::*;

    logic                clk_sys_i, rst_n_i, rise, busy_o, conversion_clock, divided_conversion_clock, done, dout, oe_n;
    logic                sclk, cs_n, cpin;
    logic [1:0]          div, mode;
    logic [RESULT_W-1:0] adc, res, exp_res;
    adcs_ser_req_t       req;
    int                  n_errors, total_checks, cyc, n, lows;
    logic [15:0]         got;
    logic                end_hi;

    // ****************************************************************
    // Clock, design and host
    // ****************************************************************
    always #4 clk_sys_i = !clk_sys_i;

    adcs_start_readback u_adcs_start_readback (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ser_req_i(req), .convert_pin_i(cpin),
        .sclk_pin_i(sclk), .cs_n_pin_i(cs_n), .sclk_active_rise_i(rise),
        .clock_divider_bit_high_i(div[1]), .clock_divider_bit_low_i(div[0]),
        .readback_select_high_i(mode[1]), .readback_select_low_i(mode[0]),
        .adc_data_i(adc), .busy_o(busy_o), .conversion_clock_o(conversion_clock),
        .divided_conversion_clock_o(divided_conversion_clock), .sample_done_o(done), .result_o(res),
        .dout_o(dout), .dout_oe_n_o(oe_n));

    adcs_host_model u_adcs_host_model (
        .clk_sys_i(clk_sys_i), .sclk_active_rise_i(rise), .dout_o(dout),
        .dout_oe_n_o(oe_n), .sclk_pin(sclk), .cs_n_pin(cs_n), .convert_pin(cpin));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", name, e, s);
        end
    endtask

    task automatic rng(input string name, input int lo, input int hi, input int s);
        total_checks++;
        if (s < lo || s > hi) begin
            n_errors++;
            $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, s);
        end
    endtask

    // One-cycle request from the serial front end.
    task automatic pulse(input logic s, input logic r, input logic hi, input logic l16);
        @(posedge clk_sys_i);
        req <= '{start: s, read: r, addr_high: hi, len16: l16};
        @(posedge clk_sys_i);
        req <= '0;
    endtask

    // Count cycles until busy (sel 0) or the completion pulse (sel 1) reaches lvl.
    task automatic wait_for(input bit sel, input logic lvl, input int lim, output int c);
        c = 0;
        do begin
            @(negedge clk_sys_i);
            c++;
        end while (((sel ? done : busy_o) !== lvl) && c < lim);
    endtask

    // Completion: the result equals the converter word held across the conversion.
    task automatic finish_conv();
        wait_for(0, 1'b0, 8000, n);
        chk("done with busy fall", 16'h0001, {15'h0, done});
        chk("result", {4'h0, adc}, {4'h0, res});
        exp_res = adc;
    endtask

    function automatic logic [15:0] exp_word(logic [11:0] r, logic hi, logic l16);
        logic [15:0] w;
        w = {r, 4'h0};
        if (!l16) return {8'h00, w[15:8]};
        return hi ? w : {w[7:0], w[15:8]};
    endfunction

    task automatic wrap_up();
        if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Run-length guard against a hang.
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 60000) begin
            $display("mismatch run length expected below 60000 seen %0d", cyc);
            n_errors++;
            wrap_up();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        clk_sys_i = 0; rst_n_i = 0; rise = 1; div = 0; mode = 0; adc = 12'hA5C;
        req = '0; n_errors = 0; total_checks = 0; cyc = 0; exp_res = '0;
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("reset state", 16'h0001, {res, busy_o, done, 1'b0, oe_n});
        chk("divided clock", {15'h0, conversion_clock}, {15'h0, divided_conversion_clock});
        // Start delay and busy width for every divider setting.
        for (int d = 0; d < 4; d++) begin
            @(posedge clk_sys_i);
            div <= d[1:0];
            adc <= 12'h3C1 + 12'(d);
            repeat (900) @(posedge clk_sys_i);
            pulse(1, 0, 0, 0);
            wait_for(0, 1'b1, 4000, n);
            rng("start to busy", (100 << d) - 2, (150 << d) + 8, n);
            wait_for(0, 1'b0, 8000, n);
            rng("busy width", (650 << d) - 2, (650 << d) + 2, n);
            chk("done with busy fall", 16'h0001, {15'h0, done});
            chk("result", {4'h0, 12'h3C1 + 12'(d)}, {4'h0, res});
        end
        // Queue: two starts in flight, the second overwrites; one follow-on only.
        @(posedge clk_sys_i);
        div <= 2'b00;
        pulse(1, 0, 0, 0);
        wait_for(0, 1'b1, 400, n);
        pulse(1, 0, 0, 0);
        pulse(1, 0, 0, 0);
        wait_for(0, 1'b0, 800, n);
        wait_for(0, 1'b1, 400, n);
        rng("queued busy low", 48, 52, n);
        wait_for(0, 1'b0, 800, n);
        wait_for(0, 1'b1, 300, n);
        chk("no third conversion", 16'h0000, {15'h0, busy_o});
        // Pin start aborts a running conversion, chip select high.
        pulse(1, 0, 0, 0);
        wait_for(0, 1'b1, 400, n);
        repeat (100) @(posedge clk_sys_i);
        fork
            u_adcs_host_model.pin_pulse();
            wait_for(1, 1'b1, 2000, n);
        join
        rng("abort restart", 750, 820, n);
        exp_res = adc;
        // Pin start with readback armed never drives the output.
        @(posedge clk_sys_i);
        mode <= 2'b01;
        u_adcs_host_model.select(1'b1);
        u_adcs_host_model.pin_pulse();
        finish_conv();
        u_adcs_host_model.frame(8, got, lows, end_hi);
        chk("pin readback", 16'h0000, 16'(lows));
        u_adcs_host_model.select(1'b0);
        // Three automatic modes, then three manual reads, one on falling clock.
        for (int k = 0; k < 6; k++) begin
            logic hi, l16;
            hi  = (k % 3) != 1;
            l16 = (k % 3) != 2;
            @(posedge clk_sys_i);
            mode <= (k < 3) ? 2'(k + 1) : 2'b00;
            rise <= (k != 4);
            adc  <= 12'h5E7 ^ 12'(k * 12'h111);
            u_adcs_host_model.select(1'b1);
            pulse(k < 3, k >= 3, hi, l16);
            u_adcs_host_model.frame(l16 ? 16 : 8, got, lows, end_hi);
            chk("readback word", exp_word(exp_res, hi, l16), got);
            chk("frame enable", {16'(l16 ? 16 : 8)}, 16'(lows));
            chk("frame end", 16'h0001, {15'h0, end_hi});
            if (k < 3) finish_conv();
            u_adcs_host_model.select(1'b0);
        end
        wrap_up();
    end
endmodule
